// ===== hw/clock_pulse_gen_defines.svh
// Constants for the clock pulse generator and halt detector
`ifndef CLOCK_PULSE_GEN_DEFINES_SVH
`define CLOCK_PULSE_GEN_DEFINES_SVH
`define CLKGEN_PRESCALE_BITS 13
`define CLKGEN_TIMER_PINS 6
`define CLKGEN_HALT_WINDOW_NS 1000
`define CLKGEN_HALT_CYCLES ((`CLKGEN_HALT_WINDOW_NS) / 5)
`define CLKGEN_SETTLE_NS 20000
`define CLKGEN_SETTLE_CYCLES ((`CLKGEN_SETTLE_NS) / 5)
`define CLKGEN_MULT_X1 2'h0
`define CLKGEN_MULT_X2 2'h1
`define CLKGEN_MULT_X4 2'h2
`define CLKGEN_MULT_RSVD 2'h3
`endif

// ===== hw/clock_pulse_gen_pkg.sv
// Types shared by the clock pulse generator files
package clock_pulse_gen_pkg;
  typedef enum logic [1:0] {MULT_X1, MULT_X2, MULT_X4, MULT_RESERVED}
    pll_mult_t;
  typedef struct packed {
    logic [1:0] opMode;
    pll_mult_t pllMult;
    logic clkModeValid;
  } mode_sel_t;
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } timer_pins_t;
endpackage

// ===== hw/edge_activity_mon.sv
// Watches the external clock input for edges and flags a halt
`timescale 1ns/1ps
`include "clock_pulse_gen_defines.svh"
module edge_activity_mon #(
  parameter int HALT_CYCLES = `CLKGEN_HALT_CYCLES
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic extClockIn,
  output logic clockHalted
);
  logic syncA;
  logic syncB;
  logic syncLast;
  logic [15:0] idleCount;
  wire edgeSeen = syncB ^ syncLast;
  wire limitHit = (idleCount == 16'(HALT_CYCLES - 1));

  // Sampling clock is the on-chip system clock, independent of the PLL
  always_ff @(posedge clk_sys)
  begin
    syncA <= extClockIn;
    syncB <= syncA;
    syncLast <= syncB;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      idleCount <= 16'h0000;
      clockHalted <= 1'b0;
    end
    else if (edgeSeen)
    begin
      idleCount <= 16'h0000;
      clockHalted <= 1'b0;
    end
    else if (limitHit)
      clockHalted <= 1'b1; // [RULE_11]
    else
      idleCount <= idleCount + 16'h0001;
  end

  chk_halt_after_idle: assert property ( // [RULE_11]
    @(posedge clk_sys) disable iff (sys_rst)
    limitHit && !edgeSeen |=> clockHalted)
    else $error("halt not flagged after idle window");
endmodule

// ===== hw/clock_pulse_gen.sv
// Clock pulse generator: prescaler, mode pins, halt and standby pin control
`timescale 1ns/1ps
`include "clock_pulse_gen_defines.svh"
// Summary of operation
// RULE_01: Prescaler divides system clock by 2 up to 8192 for peripherals.
// RULE_02: Missing input clock edges force six timer pins to high impedance.
// RULE_03: Standby also forces the six timer pins to high impedance.
// RULE_04: Leaving standby returns the six pins to their configured function.
// RULE_05: Halt outside standby stays latched until reset; the code latches it only in ST_RUN, not in ST_SETTLE.
// RULE_06: External source holds its output high while stopped for standby.
// RULE_07: Settling time elapses after reset or standby release before run.
// RULE_08: Low mode pin pair selects the operating mode.
// RULE_09: High mode pin pair selects the PLL multiplication.
// RULE_10: Codes 00 x1, 01 x2, 10 x4; 11 reserved for programming.
// RULE_11: Halt detected by a no-edge interval timed with the system clock.
module clock_pulse_gen
  import clock_pulse_gen_pkg::*;
#(
  parameter int SETTLE_CYCLES = `CLKGEN_SETTLE_CYCLES,
  parameter int HALT_CYCLES = `CLKGEN_HALT_CYCLES
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ext_clock_in,
  input wire logic op_mode_sel_0,
  input wire logic op_mode_sel_1,
  input wire logic clk_mode_sel_0,
  input wire logic clk_mode_sel_1,
  input wire logic standbyReq,
  input wire timer_pins_t pinFuncIn,
  output timer_pins_t timerPins,
  output logic [12:0] periphClk,
  output mode_sel_t modeSel,
  output logic oscHalt,
  output logic clockStable
);
  typedef enum logic [1:0] {ST_SETTLE, ST_RUN, ST_STANDBY, ST_HALTED}
    ctl_state_t;
  ctl_state_t state;
  ctl_state_t next_state;
  logic [12:0] prescale;
  logic [31:0] settleCount;
  logic haltRaw;

  // ******************************
  // Halt detector
  // ******************************
  edge_activity_mon #(.HALT_CYCLES(HALT_CYCLES)) u_mon (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .extClockIn(ext_clock_in),
    .clockHalted(haltRaw)
  );

  function automatic pll_mult_t decodeMult(input logic [1:0] code);
    unique case (code)
      2'h0: decodeMult = MULT_X1;
      2'h1: decodeMult = MULT_X2;
      2'h2: decodeMult = MULT_X4;
      2'h3: decodeMult = MULT_RESERVED;
    endcase
  endfunction

  // ******************************
  // Mode pins
  // ******************************
  wire [1:0] clkCode = {clk_mode_sel_1, clk_mode_sel_0};
  wire [1:0] opCode = {op_mode_sel_1, op_mode_sel_0};
  wire pllMultOk = (clkCode != `CLKGEN_MULT_RSVD) || (opCode == 2'h3);
  wire settleDone = (settleCount >= 32'(SETTLE_CYCLES - 1));
  // Stopped standby clock sits high; halt check only in ST_RUN, not in standby or settle
  wire haltFault = haltRaw && (state == ST_RUN); // [RULE_05]

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      modeSel <= '{opMode: 2'h0, pllMult: MULT_X1, clkModeValid: 1'b0};
    else
    begin
      modeSel.opMode <= opCode; // [RULE_08]
      modeSel.pllMult <= decodeMult(clkCode); // [RULE_09] [RULE_10]
      modeSel.clkModeValid <= pllMultOk; // [RULE_10]
    end
  end

  // ******************************
  // Prescaler
  // ******************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prescale <= 13'h0000;
    else
      prescale <= prescale + 13'h0001; // [RULE_01]
  end

  // Bit n toggles at system clock divided by 2^(n+1): /2 .. /8192
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      periphClk <= 13'h0000;
    else
      periphClk <= prescale; // [RULE_01]
  end

  // ******************************
  // Control state
  // ******************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_SETTLE:
        if (settleDone)
          next_state = ST_RUN; // [RULE_07]
      ST_RUN:
        if (haltFault)
          next_state = ST_HALTED; // [RULE_05]
        else if (standbyReq)
          next_state = ST_STANDBY;
      ST_STANDBY:
        if (!standbyReq)
          next_state = ST_SETTLE; // [RULE_04] [RULE_07]
      ST_HALTED:
        next_state = ST_HALTED; // [RULE_05]
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= ST_SETTLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || state != ST_SETTLE)
      settleCount <= 32'h00000000;
    else
      settleCount <= settleCount + 32'h00000001; // [RULE_07]
  end

  // ******************************
  // Timer pin override
  // ******************************
  wire forceHiZ = haltRaw || (state == ST_STANDBY) || (state == ST_HALTED);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timerPins <= '0;
      oscHalt <= 1'b0;
      clockStable <= 1'b0;
    end
    else
    begin
      timerPins.out <= pinFuncIn.out;
      // [RULE_02] [RULE_03] [RULE_04]
      timerPins.oe <= forceHiZ ? 6'h00 : pinFuncIn.oe;
      oscHalt <= (next_state == ST_HALTED); // [RULE_05]
      clockStable <= (next_state == ST_RUN); // [RULE_07]
    end
  end

  sequence seqStandbyEnter;
    state == ST_RUN && standbyReq && !haltFault;
  endsequence

  sequence seqHaltInRun;
    state == ST_RUN && haltFault;
  endsequence

  // Pins are free only when neither halt nor standby holds them
  sequence seqPinsFree;
    !haltRaw && (state == ST_SETTLE || state == ST_RUN);
  endsequence

  chk_halt_forces_hiz: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (sys_rst)
    haltRaw |=> timerPins.oe == 6'h00)
    else $error("pins driven during halt");
  chk_standby_forces_hiz: assert property ( // [RULE_03]
    @(posedge clk_sys) disable iff (sys_rst)
    seqStandbyEnter ##1 1'b1 |=> timerPins.oe == 6'h00)
    else $error("pins driven in standby");
  chk_release_after_standby: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (sys_rst)
    state == ST_STANDBY && !standbyReq |=> state == ST_SETTLE)
    else $error("standby exit skipped settling");
  chk_pins_follow_ctrl: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (sys_rst)
    seqPinsFree |=> timerPins.oe == $past(pinFuncIn.oe))
    else $error("pin enables not released");
  chk_pin_levels_pass: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> timerPins.out == $past(pinFuncIn.out))
    else $error("pin levels not passed through");
  chk_halt_sticks: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (sys_rst)
    state == ST_HALTED |=> state == ST_HALTED ##1 oscHalt)
    else $error("halt state left without reset");
  chk_halt_latches: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (sys_rst)
    seqHaltInRun |=> oscHalt && state == ST_HALTED)
    else $error("halt in run not latched");
  chk_settle_before_run: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(clockStable) |-> $past(settleDone))
    else $error("run entered before settling");
  chk_op_mode_pins: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> modeSel.opMode == $past(opCode))
    else $error("operating mode mismatch");
  chk_pll_mult_map: assert property ( // [RULE_09]
    @(posedge clk_sys) disable iff (sys_rst)
    clkCode == 2'h2 |=> modeSel.pllMult == MULT_X4)
    else $error("clock mode decode wrong");
  chk_pll_mult_x1: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (sys_rst)
    clkCode == 2'h0 |=> modeSel.pllMult == MULT_X1)
    else $error("times one decode wrong");
  chk_pll_mult_x2: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (sys_rst)
    clkCode == 2'h1 |=> modeSel.pllMult == MULT_X2)
    else $error("times two decode wrong");
  chk_reserved_mult: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (sys_rst)
    clkCode == 2'h3 && opCode != 2'h3 |=> !modeSel.clkModeValid)
    else $error("reserved clock mode accepted");
  chk_prescale_divide: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (sys_rst)
    periphClk[0] |=> !periphClk[0])
    else $error("divide by two output wrong");
endmodule

// ===== verification/ext_clock_source.sv
// External clock source model feeding the oscillator input
`timescale 1ns/1ps
module ext_clock_source #(
  parameter int HALF_NS = 50
)(
  input wire logic enable,
  input wire logic fault,
  output logic extClk
);
  initial extClk = 1'b1;
  // With enable low, a fault sticks the line low, as a dead oscillator would
  always
  begin
    #(HALF_NS);
    if (enable)
      extClk = ~extClk;
    else if (fault)
      extClk = 1'b0;
    else
      extClk = 1'b1;
  end
endmodule

// ===== verification/tb_clock_pulse_gen.sv
// Self-checking bench for the clock pulse generator
`timescale 1ns/1ps
module tb_clock_pulse_gen;
  import clock_pulse_gen_pkg::*;
  typedef struct {int kind; logic [11:0] val;} note_t;
  localparam int SETTLE = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b1;
  logic fault = 1'b0;
  logic standbyReq = 1'b0;
  logic [3:0] pins = 4'h0;
  timer_pins_t pinFuncIn = '0;
  timer_pins_t timerPins;
  logic [12:0] periphClk;
  mode_sel_t modeSel;
  logic oscHalt;
  logic clockStable;
  logic extClk;
  int fail_count = 0;
  int checked = 0;
  note_t notes[$];
  note_t n;
  always #2.5 clk_sys = ~clk_sys;
  ext_clock_source ext_clock_source_inst (.enable(run), .fault(fault),
    .extClk(extClk));
  clock_pulse_gen #(.SETTLE_CYCLES(SETTLE), .HALT_CYCLES(40))
    clock_pulse_gen_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ext_clock_in(extClk), .op_mode_sel_0(pins[0]),
    .op_mode_sel_1(pins[1]), .clk_mode_sel_0(pins[2]),
    .clk_mode_sel_1(pins[3]), .standbyReq(standbyReq),
    .pinFuncIn(pinFuncIn), .timerPins(timerPins), .periphClk(periphClk),
    .modeSel(modeSel), .oscHalt(oscHalt), .clockStable(clockStable));
  task automatic bad(string m);
    fail_count++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic note(int k, logic [11:0] v);
    notes.push_back('{k, v});
  endtask
  task automatic wait_flag(bit halt, int lim);
    for (int i = 0; i < lim; i++)
    begin
      step();
      if ((halt ? oscHalt : clockStable) === 1'b1)
        return;
    end
    bad("wait ran out");
    close_out();
  endtask
  // ****************
  // Output watcher
  // ****************
  task automatic compare_mode(logic [11:0] v);
    checked++;
    if (modeSel !== v[4:0])
      bad("mode select");
  endtask
  task automatic compare_pins(logic [11:0] v);
    checked++;
    if (timerPins !== v)
      bad("timer pins");
  endtask
  task automatic compare_halt(logic [11:0] v);
    checked++;
    if (oscHalt !== v[0])
      bad("halt flag");
  endtask
  task automatic compare_prescale(logic [11:0] v);
    checked++;
    if (periphClk[v[11:8]] !== v[0])
      bad("prescaler");
  endtask
  task automatic compare_stable(logic [11:0] v);
    checked++;
    if (clockStable !== v[0])
      bad("clock stable");
  endtask
  always @(negedge clk_sys)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      if (n.kind == 0)
        compare_mode(n.val);
      else if (n.kind == 1)
        compare_pins(n.val);
      else if (n.kind == 2)
        compare_halt(n.val);
      else if (n.kind == 3)
        compare_prescale(n.val);
      else
        compare_stable(n.val);
    end
  initial
  begin
    logic [12:0] p;
    logic ok;
    void'($urandom(32'h26B2));
    repeat (12) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    // Run must not start a cycle before the settle count is through
    repeat (SETTLE - 1) step();
    note(4, 12'h0);
    step();
    note(4, 12'h1);
    for (int c = 0; c < 16; c++)
    begin
      pins = 4'(c);
      step();
      ok = pins[3:2] != 2'h3 || pins[1:0] == 2'h3;
      note(0, {7'h0, pins[1:0], pins[3:2], ok});
    end
    repeat (8)
    begin
      pinFuncIn = 12'($urandom());
      step();
      note(1, pinFuncIn);
    end
    // Each stage must invert after exactly half its period
    for (int i = 0; i < 13; i++)
    begin
      @(negedge clk_sys);
      p = periphClk;
      repeat (1 << i) @(posedge clk_sys);
      #1;
      note(3, {4'(i), 7'h0, ~p[i]});
    end
    pinFuncIn = '1;
    standbyReq = 1'b1;
    step();
    step();
    note(1, {6'h3F, 6'h00});
    run = 1'b0;
    repeat (100) step();
    note(1, {6'h3F, 6'h00});
    note(2, 12'h0);
    run = 1'b1;
    standbyReq = 1'b0;
    wait_flag(0, 80);
    step();
    note(1, 12'hFFF);
    fault = 1'b1;
    run = 1'b0;
    wait_flag(1, 80);
    step();
    note(1, {6'h3F, 6'h00});
    fault = 1'b0;
    run = 1'b1;
    repeat (50) step();
    note(2, 12'h1);
    note(1, {6'h3F, 6'h00});
    sys_rst = 1'b1;
    repeat (3) step();
    sys_rst = 1'b0;
    step();
    note(2, 12'h0);
    note(4, 12'h0);
    step();
    close_out();
  end
endmodule
